// file: design/cfgblk_defines.vh
// Shared offsets, field positions and reset values of the configurable block
`ifndef CFGBLK_DEFINES_VH
`define CFGBLK_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CFGBLK_OFS_SLICE0_CFG 8'h00
`define CFGBLK_OFS_SLICE1_CFG 8'h04
`define CFGBLK_OFS_TABLE0     8'h08
`define CFGBLK_OFS_TABLE1     8'h0c
`define CFGBLK_OFS_TABLE2     8'h10
`define CFGBLK_OFS_TABLE3     8'h14
`define CFGBLK_OFS_STATUS     8'h18

// ****************************************************************
// Slice configuration word fields
// ****************************************************************
`define CFGBLK_F_MODE0_LO   0
`define CFGBLK_F_MODE1_LO   2
`define CFGBLK_F_COMB_LO    4
`define CFGBLK_F_LATCH      6
`define CFGBLK_F_BYP0       7
`define CFGBLK_F_BYP1       8
`define CFGBLK_F_INIT0      9
`define CFGBLK_F_INIT1      10
`define CFGBLK_F_ASYNC      11
`define CFGBLK_F_INV_CLK    12
`define CFGBLK_F_INV_CE     13
`define CFGBLK_F_INV_ISF    14
`define CFGBLK_F_INV_OSF    15

// Table modes
`define CFGBLK_MODE_FUNC    2'h0
`define CFGBLK_MODE_RAM     2'h1
`define CFGBLK_MODE_SHIFT   2'h2

// RAM combine modes of a slice
`define CFGBLK_COMB_SEP     2'h0
`define CFGBLK_COMB_W2      2'h1
`define CFGBLK_COMB_D32     2'h2
`define CFGBLK_COMB_DUAL    2'h3

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define CFGBLK_RST_CFG      16'h0000
`define CFGBLK_RST_TABLE    16'h0000
`define CFGBLK_RESP_OKAY    2'h0
`define CFGBLK_RESP_SLVERR  2'h2

`endif

// file: design/cfgblk_slice.v
// One slice: two lookup tables, wide combiner and two storage elements
`timescale 1ns/1ps
`include "cfgblk_defines.vh"

module cfgblk_slice (
  clk,
  resetn,
  cfg,
  tbl_ld,
  tbl_ld_data,
  addr0,
  addr1,
  addr_hi,
  wr_data,
  wr_en,
  fx_data,
  f5_sel,
  slice_clk,
  clk_en,
  init_state_force,
  opposite_state_force,
  lut_y,
  f5_y,
  q,
  tbl0,
  tbl1
);
  input  wire        clk;
  input  wire        resetn;
  input  wire [15:0] cfg;
  input  wire [1:0]  tbl_ld;
  input  wire [15:0] tbl_ld_data;
  input  wire [3:0]  addr0;
  input  wire [3:0]  addr1;
  input  wire        addr_hi;
  input  wire [1:0]  wr_data;
  input  wire        wr_en;
  input  wire [1:0]  fx_data;
  input  wire        f5_sel;
  input  wire        slice_clk;
  input  wire        clk_en;
  input  wire        init_state_force;
  input  wire        opposite_state_force;
  output wire [1:0]  lut_y;
  output wire        f5_y;
  output reg  [1:0]  q;
  output reg  [15:0] tbl0;
  output reg  [15:0] tbl1;

  // Table tap at a four-bit address
  function tap;
    input [15:0] t;
    input [3:0]  a;
    begin
      tap = t[a];
    end
  endfunction

  // Next value of one storage element, forces first
  function ff_next;
    input qv, d, init, latch, edg, lvl, ce, isf, osf, async;
    begin
      if (isf & (async | edg))
        ff_next = init;
      else if (osf & (async | edg))
        ff_next = ~init;
      else if (latch ? (lvl & ce) : (edg & ce))
        ff_next = d;
      else
        ff_next = qv;
    end
  endfunction

  // Table write into a held word
  function [15:0] wr_bit;
    input [15:0] t;
    input [3:0]  a;
    input        b;
    reg   [15:0] m;
    begin
      m      = 16'h0001 << a;
      wr_bit = b ? (t | m) : (t & ~m);
    end
  endfunction

  // ****************************************************************
  // Control polarity and slice clock edge
  // ****************************************************************
  wire       ck_i  = slice_clk ^ cfg[`CFGBLK_F_INV_CLK];
  wire       ce_i  = clk_en ^ cfg[`CFGBLK_F_INV_CE];
  wire       isf_i = init_state_force ^ cfg[`CFGBLK_F_INV_ISF];
  wire       osf_i = opposite_state_force ^ cfg[`CFGBLK_F_INV_OSF];
  wire [1:0] mode0 = cfg[`CFGBLK_F_MODE0_LO+1:`CFGBLK_F_MODE0_LO];
  wire [1:0] mode1 = cfg[`CFGBLK_F_MODE1_LO+1:`CFGBLK_F_MODE1_LO];
  wire [1:0] comb  = cfg[`CFGBLK_F_COMB_LO+1:`CFGBLK_F_COMB_LO];
  reg        ck_prev_r;
  wire       edge_w = ck_i & ~ck_prev_r;

  // ****************************************************************
  // Lookup table read paths
  // ****************************************************************
  wire       pair   = (comb == `CFGBLK_COMB_W2) | (comb == `CFGBLK_COMB_D32);
  wire [3:0] rd1    = pair ? addr0 : addr1;
  wire [3:0] wa1    = (comb == `CFGBLK_COMB_SEP) ? addr1 : addr0;
  wire       wd1    = (comb == `CFGBLK_COMB_DUAL) ? wr_data[0] : wr_data[1];
  wire       d32    = (comb == `CFGBLK_COMB_D32);
  assign lut_y[0] = tap(tbl0, addr0);
  assign lut_y[1] = tap(tbl1, rd1);
  // Five-input combiner, or the depth select of the 32 x 1 RAM
  assign f5_y = (d32 ? addr_hi : f5_sel) ? lut_y[1] : lut_y[0];

  // Write strobes of each table in RAM mode and shift strobes in shift mode
  wire we0 = edge_w & wr_en & (mode0 == `CFGBLK_MODE_RAM) & ~(d32 & addr_hi);
  wire we1 = edge_w & wr_en & (mode1 == `CFGBLK_MODE_RAM) & ~(d32 & ~addr_hi);
  wire sh0 = edge_w & ce_i & (mode0 == `CFGBLK_MODE_SHIFT);
  wire sh1 = edge_w & ce_i & (mode1 == `CFGBLK_MODE_SHIFT);

  // Storage element data select
  wire d0 = cfg[`CFGBLK_F_BYP0] ? fx_data[0] : lut_y[0];
  wire d1 = cfg[`CFGBLK_F_BYP1] ? fx_data[1] : lut_y[1];

  // ****************************************************************
  // Tables, edge history and storage elements
  // ****************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ck_prev_r <= 1'b0;
      tbl0      <= `CFGBLK_RST_TABLE;
      tbl1      <= `CFGBLK_RST_TABLE;
      q         <= 2'b00;
    end else begin
      ck_prev_r <= ck_i;
      // Software load wins over user writes in the same cycle
      if (tbl_ld[0])
        tbl0 <= tbl_ld_data;
      else if (we0)
        tbl0 <= wr_bit(tbl0, addr0, wr_data[0]);
      else if (sh0)
        tbl0 <= {tbl0[14:0], wr_data[0]};
      if (tbl_ld[1])
        tbl1 <= tbl_ld_data;
      else if (we1)
        tbl1 <= wr_bit(tbl1, wa1, wd1);
      else if (sh1)
        tbl1 <= {tbl1[14:0], wr_data[1]};
      // Both cells share the slice clock, enable and forces
      q[0] <= ff_next(q[0], d0, cfg[`CFGBLK_F_INIT0], cfg[`CFGBLK_F_LATCH], edge_w, ck_i,
                      ce_i, isf_i, osf_i, cfg[`CFGBLK_F_ASYNC]);
      q[1] <= ff_next(q[1], d1, cfg[`CFGBLK_F_INIT1], cfg[`CFGBLK_F_LATCH], edge_w, ck_i,
                      ce_i, isf_i, osf_i, cfg[`CFGBLK_F_ASYNC]);
    end
  end

endmodule // cfgblk_slice

// file: design/cfgblk_top.v
// Configurable block of two slices with an AXI4-Lite configuration port
// Overview of operation
// - each cell has a four-input table and one storage element
// - the block holds four cells as two identical two-cell slices
// - combining muxes join tables into any five- or six-input function
// - each table works as a function or as a 16 x 1 synchronous RAM
// - the two tables of a slice form 16 x 2, 32 x 1 or 16 x 1 dual-port RAM
// - each table can instead act as a 16-bit shift register
// - storage element is an edge flip-flop or a transparent latch by configuration
// - storage element data comes from the table or a direct bypass input
// - the init force drives the element to its configured start value
// - the opposite force drives the element to the complement of that value
// - forces act on the clock edge by default, or at once if configured
// - in flip-flop mode an element loads data only on an active slice clock edge with enable
// - clock, enable and forces are each invertible and shared inside a slice
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "cfgblk_defines.vh"

module cfgblk_top #(
  parameter ADDR_W = 8
) (
  clk,
  resetn,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  lut_addr,
  addr_hi,
  wr_data,
  wr_en,
  fx_data,
  f5_sel,
  f6_sel,
  slice_clk,
  clk_en,
  init_state_force,
  opposite_state_force,
  lut_out,
  f5_out,
  f6_out,
  q_out
);
  input  wire              clk;
  input  wire              resetn;
  input  wire [ADDR_W-1:0] s_axi_awaddr;
  input  wire              s_axi_awvalid;
  output reg               s_axi_awready;
  input  wire [31:0]       s_axi_wdata;
  input  wire [3:0]        s_axi_wstrb;
  input  wire              s_axi_wvalid;
  output reg               s_axi_wready;
  output reg  [1:0]        s_axi_bresp;
  output reg               s_axi_bvalid;
  input  wire              s_axi_bready;
  input  wire [ADDR_W-1:0] s_axi_araddr;
  input  wire              s_axi_arvalid;
  output reg               s_axi_arready;
  output reg  [31:0]       s_axi_rdata;
  output reg  [1:0]        s_axi_rresp;
  output reg               s_axi_rvalid;
  input  wire              s_axi_rready;
  input  wire [15:0]       lut_addr;
  input  wire [1:0]        addr_hi;
  input  wire [3:0]        wr_data;
  input  wire [1:0]        wr_en;
  input  wire [3:0]        fx_data;
  input  wire [1:0]        f5_sel;
  input  wire              f6_sel;
  input  wire [1:0]        slice_clk;
  input  wire [1:0]        clk_en;
  input  wire [1:0]        init_state_force;
  input  wire [1:0]        opposite_state_force;
  output reg  [3:0]        lut_out;
  output reg  [1:0]        f5_out;
  output reg               f6_out;
  output wire [3:0]        q_out;

  // Byte-lane merge of a write into a 32-bit word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // Offset is one of the mapped words
  function mapped;
    input [7:0] a;
    begin
      mapped = (a <= `CFGBLK_OFS_STATUS) & (a[1:0] == 2'b00);
    end
  endfunction

  // ****************************************************************
  // Configuration state and slice wiring
  // ****************************************************************
  reg  [15:0]       cfg0_r;
  reg  [15:0]       cfg1_r;
  reg  [3:0]        tbl_ld_r;
  reg  [15:0]       tbl_ld_data_r;
  wire [15:0]       tbl [0:3];
  wire [3:0]        lut_y;
  wire [1:0]        f5_y;
  wire              f6_y;

  // ****************************************************************
  // Write channel state
  // ****************************************************************
  reg               aw_got_r;
  reg               w_got_r;
  reg  [7:0]        wa_r;
  reg  [31:0]       wd_r;
  reg  [3:0]        ws_r;
  wire              aw_take = s_axi_awvalid & s_axi_awready;
  wire              w_take  = s_axi_wvalid & s_axi_wready;
  wire              wr_go   = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire              ar_take = s_axi_arvalid & s_axi_arready;
  wire [7:0]        ra_w    = s_axi_araddr[7:0];

  // Word at one offset; status shows cell outputs and stored states
  function [31:0] reg_word;
    input [7:0] a;
    begin
      case (a)
        `CFGBLK_OFS_SLICE0_CFG : reg_word = {16'h0000, cfg0_r};
        `CFGBLK_OFS_SLICE1_CFG : reg_word = {16'h0000, cfg1_r};
        `CFGBLK_OFS_TABLE0     : reg_word = {16'h0000, tbl[0]};
        `CFGBLK_OFS_TABLE1     : reg_word = {16'h0000, tbl[1]};
        `CFGBLK_OFS_TABLE2     : reg_word = {16'h0000, tbl[2]};
        `CFGBLK_OFS_TABLE3     : reg_word = {16'h0000, tbl[3]};
        `CFGBLK_OFS_STATUS     : reg_word = {21'h000000, f6_out, f5_out, lut_out, q_out};
        default                : reg_word = 32'h00000000;
      endcase
    end
  endfunction

  // Read word, and the held write merged into the current word
  wire [31:0]       rd_w    = reg_word(ra_w);
  wire [31:0]       mrg_w   = merge(reg_word(wa_r), wd_r, ws_r);

  // ****************************************************************
  // AXI4-Lite write: address and data in either order, then response
  // ****************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CFGBLK_RESP_OKAY;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      wa_r          <= 8'h00;
      wd_r          <= 32'h00000000;
      ws_r          <= 4'h0;
      cfg0_r        <= `CFGBLK_RST_CFG;
      cfg1_r        <= `CFGBLK_RST_CFG;
      tbl_ld_r      <= 4'h0;
      tbl_ld_data_r <= `CFGBLK_RST_TABLE;
    end else begin
      tbl_ld_r      <= 4'h0;
      s_axi_awready <= ~aw_got_r & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_got_r & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_got_r <= 1'b1;
        wa_r     <= s_axi_awaddr[7:0];
      end
      if (w_take) begin
        w_got_r <= 1'b1;
        wd_r    <= s_axi_wdata;
        ws_r    <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r      <= 1'b0;
        w_got_r       <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= mapped(wa_r) ? `CFGBLK_RESP_OKAY : `CFGBLK_RESP_SLVERR;
        tbl_ld_data_r <= mrg_w[15:0];
        case (wa_r)
          `CFGBLK_OFS_SLICE0_CFG : cfg0_r <= mrg_w[15:0];
          `CFGBLK_OFS_SLICE1_CFG : cfg1_r <= mrg_w[15:0];
          `CFGBLK_OFS_TABLE0     : tbl_ld_r <= 4'h1;
          `CFGBLK_OFS_TABLE1     : tbl_ld_r <= 4'h2;
          `CFGBLK_OFS_TABLE2     : tbl_ld_r <= 4'h4;
          `CFGBLK_OFS_TABLE3     : tbl_ld_r <= 4'h8;
          default                : tbl_ld_r <= 4'h0;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read: one cycle from address to data
  // ****************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CFGBLK_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_w;
        s_axi_rresp  <= mapped(ra_w) ? `CFGBLK_RESP_OKAY : `CFGBLK_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Two identical slices of two cells each
  // ****************************************************************
  cfgblk_slice u_slice0 (
    .clk                  (clk),
    .resetn               (resetn),
    .cfg                  (cfg0_r),
    .tbl_ld               (tbl_ld_r[1:0]),
    .tbl_ld_data          (tbl_ld_data_r),
    .addr0                (lut_addr[3:0]),
    .addr1                (lut_addr[7:4]),
    .addr_hi              (addr_hi[0]),
    .wr_data              (wr_data[1:0]),
    .wr_en                (wr_en[0]),
    .fx_data              (fx_data[1:0]),
    .f5_sel               (f5_sel[0]),
    .slice_clk            (slice_clk[0]),
    .clk_en               (clk_en[0]),
    .init_state_force     (init_state_force[0]),
    .opposite_state_force (opposite_state_force[0]),
    .lut_y                (lut_y[1:0]),
    .f5_y                 (f5_y[0]),
    .q                    (q_out[1:0]),
    .tbl0                 (tbl[0]),
    .tbl1                 (tbl[1])
  );

  cfgblk_slice u_slice1 (
    .clk                  (clk),
    .resetn               (resetn),
    .cfg                  (cfg1_r),
    .tbl_ld               (tbl_ld_r[3:2]),
    .tbl_ld_data          (tbl_ld_data_r),
    .addr0                (lut_addr[11:8]),
    .addr1                (lut_addr[15:12]),
    .addr_hi              (addr_hi[1]),
    .wr_data              (wr_data[3:2]),
    .wr_en                (wr_en[1]),
    .fx_data              (fx_data[3:2]),
    .f5_sel               (f5_sel[1]),
    .slice_clk            (slice_clk[1]),
    .clk_en               (clk_en[1]),
    .init_state_force     (init_state_force[1]),
    .opposite_state_force (opposite_state_force[1]),
    .lut_y                (lut_y[3:2]),
    .f5_y                 (f5_y[1]),
    .q                    (q_out[3:2]),
    .tbl0                 (tbl[2]),
    .tbl1                 (tbl[3])
  );

  // Six-input combiner picks one of the slice combiners
  assign f6_y = f6_sel ? f5_y[1] : f5_y[0];

  // ****************************************************************
  // Registered block outputs
  // ****************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lut_out <= 4'h0;
      f5_out  <= 2'h0;
      f6_out  <= 1'b0;
    end else begin
      lut_out <= lut_y;
      f5_out  <= f5_y;
      f6_out  <= f6_y;
    end
  end

endmodule // cfgblk_top

// file: sim/cfgblk_top_monitor.sv
// Protocol and combiner checker bound to the configurable block
`timescale 1ns/1ps
module cfgblk_top_monitor #(
  parameter ADDR_W = 8
) (
  input wire        clk,
  input wire        resetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        f6_sel,
  input wire [1:0]  f5_out,
  input wire        f6_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****************************************************************
  // Bus steps
  // ****************************************************************
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence s_r_done;
    s_axi_rvalid && s_axi_rready;
  endsequence
  chk_b_latency: assert property (s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after take");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped or changed");
  chk_b_release: assert property (s_b_done |=> !s_axi_bvalid ##[0:1] (s_axi_awready && s_axi_wready))
    else $error("write channel not reopened");
  chk_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready stayed high");
  chk_w_busy: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("data ready stayed high");
  chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed");
  chk_ar_return: assert property (s_r_done |=> !s_axi_rvalid ##[0:1] s_axi_arready)
    else $error("read channel not reopened");
  chk_wide_select: assert property (f6_out == ($past(f6_sel) ? f5_out[1] : f5_out[0]))
    else $error("six input select wrong");
endmodule // cfgblk_top_monitor

bind cfgblk_top cfgblk_top_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .f6_sel, .f5_out, .f6_out
);

// file: sim/cfgblk_user_model.sv
// User logic model that drives the slice clock signals
`timescale 1ns/1ps
module cfgblk_user_model #(
  parameter HIGH_CYC = 2
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire [1:0] pulse,
  output reg  [1:0] slice_clk
);
  reg [3:0] cnt_r;
  // Hold a slice clock high for some cycles, then low, so both levels last
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slice_clk <= 2'h0;
      cnt_r     <= 4'h0;
    end else if (pulse != 2'h0) begin
      slice_clk <= pulse;
      cnt_r     <= HIGH_CYC[3:0];
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else begin
      slice_clk <= 2'h0;
    end
  end
endmodule // cfgblk_user_model

// file: sim/tb.sv
// Self-checking bench for the configurable block
`timescale 1ns/1ps
`include "cfgblk_defines.vh"
module tb;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb = 4'h0, wr_data = 4'h0, fx_data = 4'h0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, f6_sel = 1'b0;
  reg  [15:0] lut_addr = 16'h0;
  reg  [1:0]  wr_en = 2'h0, f5_sel = 2'h0, clk_en = 2'h0, isf = 2'h0, osf = 2'h0, pulse = 2'h0, hi = 2'h0;
  wire        awready, wready, bvalid, arready, rvalid, f6_out;
  wire [1:0]  bresp, rresp, slice_clk, f5_out;
  wire [31:0] rdata;
  wire [3:0]  lut_out, q_out;
  integer     errors = 0, compares = 0;
  // Clock
  always #12.5 clk = ~clk;
  cfgblk_top dut (.clk, .resetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lut_addr, .addr_hi(hi),
    .wr_data, .wr_en, .fx_data, .f5_sel, .f6_sel, .slice_clk, .clk_en, .init_state_force(isf),
    .opposite_state_force(osf), .lut_out, .f5_out, .f6_out, .q_out);
  cfgblk_user_model u_user (.clk, .resetn, .pulse, .slice_clk);
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input [31:0] seen, input [31:0] exp, input string what);
    compares = compares + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tmo;
    errors = errors + 1;
    $display("MISMATCH bus wait expected answer seen none");
    test_done;
  endtask
  // Bus write; bready raised on the answer
  task axi_wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    integer n;
    begin
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
      for (n = 0; n < 40; n = n + 1) begin
        @(posedge clk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid && bready) begin
          bready <= 1'b0;
          check(bresp, er, "bresp");
          n = 90;
        end else if (bvalid) bready <= 1'b1;
      end
      if (n < 90) tmo;
    end
  endtask
  task axi_rd(input [7:0] a, input [31:0] exp, input [1:0] er);
    integer n;
    begin
      araddr <= a; arvalid <= 1'b1;
      for (n = 0; n < 40; n = n + 1) begin
        @(posedge clk);
        if (arready) arvalid <= 1'b0;
        if (rvalid && rready) begin
          rready <= 1'b0;
          check(rdata, exp, "rdata");
          check(rresp, er, "rresp");
          n = 90;
        end else if (rvalid) rready <= 1'b1;
      end
      if (n < 90) tmo;
    end
  endtask
  // One slice clock pulse, then let the storage settle
  task spulse(input [1:0] s);
    pulse <= s;
    @(posedge clk);
    pulse <= 2'h0;
    repeat (6) @(posedge clk);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_regs;
      axi_rd(`CFGBLK_OFS_SLICE0_CFG, 32'h0, `CFGBLK_RESP_OKAY);
      axi_rd(`CFGBLK_OFS_TABLE3, 32'h0, `CFGBLK_RESP_OKAY);
      axi_wr(`CFGBLK_OFS_SLICE1_CFG, 32'h1234_5a5a, 4'hf, `CFGBLK_RESP_OKAY);
      axi_wr(`CFGBLK_OFS_SLICE1_CFG, 32'h0000_00c3, 4'h1, `CFGBLK_RESP_OKAY);
      axi_rd(`CFGBLK_OFS_SLICE1_CFG, 32'h0000_5ac3, `CFGBLK_RESP_OKAY);
      axi_wr(8'h1c, 32'hffff_ffff, 4'hf, `CFGBLK_RESP_SLVERR);
      axi_rd(8'h1c, 32'h0, `CFGBLK_RESP_SLVERR);
      axi_wr(`CFGBLK_OFS_SLICE1_CFG, 32'h0, 4'hf, `CFGBLK_RESP_OKAY);
      $display("test regs done");
  endtask
  task t_func;
    integer a;
    reg [15:0] p;
    reg b;
    begin
      p = 16'h9c35;
      axi_wr(`CFGBLK_OFS_TABLE0, {16'h0, p}, 4'hf, `CFGBLK_RESP_OKAY);
      for (a = 0; a < 16; a = a + 1) begin
        lut_addr <= {8'h00, a[3:0], a[3:0]};
        f5_sel <= {1'b0, a[0]};
        f6_sel <= a[1];
        repeat (2) @(posedge clk);
        b = p[a];
        check(lut_out[0], b, "lut_out");
        check(f5_out[0], b & ~a[0], "f5_out");
        check(f6_out, b & ~a[0] & ~a[1], "f6_out");
      end
      $display("test function done");
    end
  endtask
  task t_ff;
    begin
      clk_en <= 2'h1; lut_addr <= 16'h0000;
      spulse(2'h1);
      check(q_out[0], 1'b1, "q flop");
      clk_en <= 2'h0; lut_addr <= 16'h0001;
      spulse(2'h1);
      check(q_out[0], 1'b1, "q hold");
      axi_wr(`CFGBLK_OFS_SLICE0_CFG, 32'h0000_2080, 4'hf, `CFGBLK_RESP_OKAY);
      lut_addr <= 16'h0000;
      spulse(2'h1);
      check(q_out[0], 1'b0, "q bypass");
      axi_wr(`CFGBLK_OFS_SLICE0_CFG, 32'h0000_30c0, 4'hf, `CFGBLK_RESP_OKAY);
      fx_data <= 4'h1;
      repeat (3) @(posedge clk);
      check(q_out[0], 1'b1, "q latch open");
      fx_data <= 4'h0;
      repeat (3) @(posedge clk);
      check(q_out[0], 1'b0, "q latch follow");
      $display("test storage done");
    end
  endtask
  task t_force;
    begin
      axi_wr(`CFGBLK_OFS_SLICE0_CFG, 32'h0000_0200, 4'hf, `CFGBLK_RESP_OKAY);
      isf <= 2'h1;
      repeat (4) @(posedge clk);
      check(q_out[0], 1'b0, "q sync wait");
      spulse(2'h1);
      check(q_out[0], 1'b1, "q init");
      isf <= 2'h0; osf <= 2'h1;
      spulse(2'h1);
      check(q_out[0], 1'b0, "q opposite");
      osf <= 2'h0;
      axi_wr(`CFGBLK_OFS_SLICE0_CFG, 32'h0000_0a00, 4'hf, `CFGBLK_RESP_OKAY);
      isf <= 2'h1;
      repeat (3) @(posedge clk);
      check(q_out[0], 1'b1, "q async");
      isf <= 2'h0;
      $display("test force done");
    end
  endtask
  task t_ram;
    axi_wr(`CFGBLK_OFS_SLICE0_CFG, 32'h0000_0001, 4'hf, `CFGBLK_RESP_OKAY);
    axi_wr(`CFGBLK_OFS_SLICE1_CFG, 32'h0000_0015, 4'hf, `CFGBLK_RESP_OKAY);
    axi_wr(`CFGBLK_OFS_TABLE0, 32'h0, 4'hf, `CFGBLK_RESP_OKAY);
    lut_addr <= 16'h0305; wr_data <= 4'h9;
    spulse(2'h3);
    axi_rd(`CFGBLK_OFS_TABLE0, 32'h0, `CFGBLK_RESP_OKAY);
    wr_en <= 2'h3;
    spulse(2'h3);
    wr_en <= 2'h0;
    check(lut_out[0], 1'b1, "ram read");
    axi_rd(`CFGBLK_OFS_TABLE0, 32'h0000_0020, `CFGBLK_RESP_OKAY);
    axi_rd(`CFGBLK_OFS_TABLE2, 32'h0, `CFGBLK_RESP_OKAY);
    axi_rd(`CFGBLK_OFS_TABLE3, 32'h0000_0008, `CFGBLK_RESP_OKAY);
    // 32 x 1: upper address bit steers the write to the second table
    axi_wr(`CFGBLK_OFS_SLICE0_CFG, 32'h0000_0025, 4'hf, `CFGBLK_RESP_OKAY);
    hi <= 2'h1; wr_data <= 4'h2; wr_en <= 2'h1;
    spulse(2'h1);
    wr_en <= 2'h0; hi <= 2'h0;
    axi_rd(`CFGBLK_OFS_TABLE1, 32'h0000_0020, `CFGBLK_RESP_OKAY);
    $display("test ram done");
  endtask
  task t_shift;
    integer i;
    reg [3:0] v;
    begin
      v = 4'hb;
      axi_wr(`CFGBLK_OFS_SLICE0_CFG, 32'h0000_0002, 4'hf, `CFGBLK_RESP_OKAY);
      axi_wr(`CFGBLK_OFS_TABLE0, 32'h0, 4'hf, `CFGBLK_RESP_OKAY);
      clk_en <= 2'h1;
      for (i = 3; i >= 0; i = i - 1) begin
        wr_data <= {3'h0, v[i]};
        spulse(2'h1);
      end
      axi_rd(`CFGBLK_OFS_TABLE0, 32'h0000_000b, `CFGBLK_RESP_OKAY);
      lut_addr <= 16'h0002;
      repeat (3) @(posedge clk);
      check(lut_out[0], 1'b0, "tap two");
      lut_addr <= 16'h0003;
      repeat (3) @(posedge clk);
      check(lut_out[0], 1'b1, "tap three");
      $display("test shift done");
    end
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs;
    t_func;
    t_ff;
    t_force;
    t_ram;
    t_shift;
    test_done;
  end
endmodule // tb
